// [flash_ctrl_pkg.sv]
package flash_ctrl_pkg;
    // ----------------------------------------------------------------
    // serial link constants
    // ----------------------------------------------------------------
    localparam logic [6:0] TARGET_ADDR    = 7'h64;
    localparam int         BYTE_BITS      = 8;

    // ----------------------------------------------------------------
    // register offsets and power-on values
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_OP         = 8'h01;
    localparam logic [7:0] REG_SETUP      = 8'h02;
    localparam logic [7:0] REG_FLASH      = 8'h03;
    localparam logic [7:0] REG_TORCH      = 8'h04;
    localparam logic [7:0] REG_FLAGS      = 8'h05;
    localparam logic [7:0] REG_ID         = 8'h06;
    localparam logic [7:0] OP_RST         = 8'h20;
    localparam logic [7:0] SETUP_RST      = 8'h15;
    localparam logic [7:0] FLASH_RST      = 8'h00;
    localparam logic [7:0] TORCH_RST      = 8'h00;
    localparam logic [7:0] FLAGS_RST      = 8'h00;
    localparam logic [2:0] DEVICE_ID      = 3'h2; // arbitrary value
    localparam logic [2:0] SILICON_REV    = 3'h5; // arbitrary value

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int         OP_PASS_BIT    = 7;
    localparam int         OP_FREQ_BIT    = 6;
    localparam int         OP_ILIM_BIT    = 5;
    localparam int         OP_DROOP_BIT   = 4;
    localparam int         OP_EDGE_BIT    = 3;
    localparam int         OP_MODE_LSB    = 0;
    localparam int         SETUP_THR_LSB  = 5;
    localparam int         SETUP_TO_LSB   = 1;
    localparam int         SETUP_RAMP_BIT = 0;
    localparam int         FLASH_TSB_BIT  = 7;
    localparam int         ID_SWRST_BIT   = 7;
    localparam int         FLAG_TSB_BIT   = 3;
    localparam logic [7:0] STANDBY_FAULTS = 8'hA7;

    // ----------------------------------------------------------------
    // modes and timing
    // ----------------------------------------------------------------
    localparam logic [1:0] MODE_STANDBY   = 2'h0;
    localparam logic [1:0] MODE_IR        = 2'h1;
    localparam logic [1:0] MODE_TORCH     = 2'h2;
    localparam logic [1:0] MODE_FLASH     = 2'h3;
    localparam int         CLK_NS         = 10;
    localparam int         TORCH_RAMP_NS  = 1000000;
    localparam int         LEVEL_STEPS    = 128;
    localparam int         RAMP_STEP_CYC  = TORCH_RAMP_NS / (CLK_NS * LEVEL_STEPS);

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_ADDR = 5'b00010,
        ST_PTR  = 5'b00100,
        ST_DATA = 5'b01000,
        ST_READ = 5'b10000
    } bus_state_t;
endpackage

// [link_if.sv]
`timescale 1ns/1ps
// byte handed from the serial-clock side to the core side
interface link_if;
    logic [7:0] rx_byte;
    logic       rx_tgl;
    modport link (output rx_byte, output rx_tgl);
    modport core (input rx_byte, input rx_tgl);
endinterface

// [byte_shifter.sv]
`timescale 1ns/1ps
module byte_shifter
    import flash_ctrl_pkg::*;
(
    input  wire logic scl_clk_in,
    input  wire logic frame_rst_b_in,
    input  wire logic sda_in,
    link_if.link      rx_port
);
    typedef struct packed {
        logic [6:0] sh;
        logic [3:0] cnt;
        logic [7:0] data;
        logic       tgl;
    } shift_t;

    shift_t s_q;
    shift_t s_d;

    // ----------------------------------------------------------------
    // msb-first shifter on rising serial clock
    // ----------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        if (s_q.cnt == 4'(BYTE_BITS)) begin
            s_d.cnt = 4'h0; // ninth clock is the ack slot R5
        end else begin
            s_d.sh  = {s_q.sh[5:0], sda_in};
            s_d.cnt = s_q.cnt + 4'h1;
            if (s_q.cnt == 4'(BYTE_BITS - 1)) begin
                s_d.data = {s_q.sh, sda_in}; // R5
                s_d.tgl  = ~s_q.tgl;         // byte held stable until next toggle
            end
        end
    end

    // frame reset comes from the core on every start and stop
    always_ff @(posedge scl_clk_in or negedge frame_rst_b_in) begin
        if (!frame_rst_b_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rx_port.rx_byte = s_q.data;
    assign rx_port.rx_tgl  = s_q.tgl;
endmodule

// [flash_serial_ctrl.sv]
// Overview of operation
// R1: data changes only while clock low
// R2: start and stop seen with clock high
// R3: bus busy from start until stop
// R4: repeated start restarts address reception
// R5: eight bits msb first, then ack
// R6: device pulls data low on ninth clock
// R7: no device ack after sending read data
// R8: respond only to address 1100100 plus direction
// R9: pointer byte then data byte stored
// R10: bit 7 forces pass-through boost
// R11: bit 6 picks 2 or 4 MHz
// R12: bit 5 picks inductor current limit
// R13: bit 4 enables input droop monitor
// R14: bit 3 picks level or edge trigger
// R15: bits 1:0 pick operating mode
// R16: host avoids edge trigger in infrared
// R17: host holds trigger above 1 ms
// R18: setup bits 7:5 droop threshold
// R19: setup bits 4:1 flash time-out
// R20: setup bit 0 torch ramp enable
// R21: flash bits 6:0 current level
// R22: flash bit 7 thermal scale-back enable
// R23: fault read clears flags and lockout
// R24: id bit 7 write forces reset
// R25: led level steps toward its target
// R26: unlisted offsets acked, ignored, read zero
`timescale 1ns/1ps
module flash_serial_ctrl
    import flash_ctrl_pkg::*;
(
    input  wire logic       mclk_in,
    input  wire logic       rst_b_in,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output wire logic       sda_out_out,
    output wire logic       sda_oe_out,
    input  wire logic [7:0] fault_events_in,
    output wire logic       boost_pass_only_out,
    output wire logic       freq_4mhz_out,
    output wire logic       ilim_high_out,
    output wire logic       input_droop_monitor_out,
    output wire logic       strobe_edge_out,
    output wire logic       mode_select_high_out,
    output wire logic       mode_select_low_out,
    output wire logic [2:0] droop_threshold_out,
    output wire logic [3:0] timeout_code_out,
    output wire logic       torch_ramp_out,
    output wire logic       thermal_scaleback_out,
    output wire logic [6:0] led_level_out,
    output wire logic       led_on_out,
    output wire logic       bus_busy_out
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       scl_s1;
        logic       scl_s2;
        logic       scl_s3;
        logic       sda_s1;
        logic       sda_s2;
        logic       sda_s3;
        logic       tgl_s1;
        logic       tgl_s2;
        logic       tgl_seen;
        logic [7:0] flt_s1;
        logic [7:0] flt_s2;
        bus_state_t st;
        logic       busy;
        logic       restart;
        logic [7:0] ptr;
        logic [7:0] op;
        logic [7:0] setup;
        logic [7:0] flash;
        logic [7:0] torch;
        logic [7:0] flags;
        logic       lock;
        logic       ack_pend;
        logic       ack_on;
        logic       mack;
        logic [7:0] tx;
        logic [3:0] tx_cnt;
        logic       sda_oe;
        logic       sda_lvl;
        logic [6:0] level;
        logic       led_on;
        logic [9:0] step_cnt;
    } core_t;

    localparam core_t S_RST = '{
        st:      ST_IDLE,
        restart: 1'b1,
        op:      OP_RST,
        setup:   SETUP_RST,
        flash:   FLASH_RST,
        torch:   TORCH_RST,
        flags:   FLAGS_RST,
        default: '0
    };

    core_t      s_q;
    core_t      s_d;
    logic       frame_rst_b;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_det;
    logic       stop_det;
    logic       byte_evt;
    logic       wr_evt;
    logic       load;
    logic       rd_clr;
    logic       soft_rst;
    logic [1:0] mode;
    logic [6:0] target;
    logic [7:0] rx;

    link_if lnk ();

    // link-side shifter, held in reset between frames
    assign frame_rst_b = rst_b_in & ~s_q.restart;

    byte_shifter u_shift (
        .scl_clk_in     (scl_in),
        .frame_rst_b_in (frame_rst_b),
        .sda_in         (sda_in),
        .rx_port        (lnk.link)
    );

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [7:0] reg_read(input core_t c);
        logic [7:0] v;
        v = 8'h00; // R26
        case (c.ptr)
            REG_OP:    v = c.op;
            REG_SETUP: v = c.setup;
            REG_FLASH: v = c.flash;
            REG_TORCH: v = c.torch;
            REG_FLAGS: v = c.flags;
            REG_ID:    v = {2'h0, DEVICE_ID, SILICON_REV};
            default:   v = 8'h00;
        endcase
        return v;
    endfunction

    function automatic logic [6:0] step_toward(input logic [6:0] cur,
                                               input logic [6:0] tgt);
        logic [6:0] n;
        n = cur;
        if (cur < tgt) begin
            n = cur + 7'h01;
        end else if (cur > tgt) begin
            n = cur - 7'h01;
        end
        return n;
    endfunction

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        s_d      = s_q;
        wr_evt   = 1'b0;
        load     = 1'b0;
        rd_clr   = 1'b0;
        soft_rst = 1'b0;
        rx       = lnk.rx_byte;

        // pin and cross-domain synchronisers
        s_d.scl_s1   = scl_in;
        s_d.scl_s2   = s_q.scl_s1;
        s_d.scl_s3   = s_q.scl_s2;
        s_d.sda_s1   = sda_in;
        s_d.sda_s2   = s_q.sda_s1;
        s_d.sda_s3   = s_q.sda_s2;
        s_d.tgl_s1   = lnk.rx_tgl;
        s_d.tgl_s2   = s_q.tgl_s1;
        s_d.tgl_seen = s_q.tgl_s2;
        s_d.flt_s1   = fault_events_in;
        s_d.flt_s2   = s_q.flt_s1;

        // edges of the synchronised bus lines
        scl_rise  = s_q.scl_s2 & ~s_q.scl_s3;
        scl_fall  = ~s_q.scl_s2 & s_q.scl_s3;
        start_det = s_q.scl_s2 & s_q.scl_s3 & s_q.sda_s3 & ~s_q.sda_s2; // R2
        stop_det  = s_q.scl_s2 & s_q.scl_s3 & ~s_q.sda_s3 & s_q.sda_s2; // R2
        // data only sampled on clock edges, so mid-high changes are framing R1
        byte_evt  = (s_q.tgl_s2 != s_q.tgl_seen) & ~s_q.restart;

        // release the shifter once the clock drops after a start
        if (s_q.restart && s_q.busy && !s_q.scl_s2) begin
            s_d.restart = 1'b0;
        end

        // byte decoder
        unique case (s_q.st)
            ST_IDLE: begin
            end
            ST_ADDR: begin
                if (byte_evt) begin
                    if (rx[7:1] == TARGET_ADDR) begin // R8
                        s_d.ack_pend = 1'b1;          // R6
                        s_d.st       = rx[0] ? ST_READ : ST_PTR;
                    end else begin
                        s_d.st = ST_IDLE;
                    end
                end
            end
            ST_PTR: begin
                if (byte_evt) begin
                    s_d.ptr      = rx; // R9
                    s_d.ack_pend = 1'b1;
                    s_d.st       = ST_DATA;
                end
            end
            ST_DATA: begin
                if (byte_evt) begin
                    wr_evt       = 1'b1; // R9
                    s_d.ack_pend = 1'b1; // R26
                end
            end
            ST_READ: begin
            end
            default: s_d.st = ST_IDLE;
        endcase

        // register writes; unlisted offsets fall through R26
        if (wr_evt) begin
            case (s_q.ptr)
                REG_OP:    s_d.op    = rx; // R10 R11 R12 R13 R14 R15
                REG_SETUP: s_d.setup = rx; // R18 R19 R20
                REG_FLASH: s_d.flash = rx; // R21 R22
                REG_TORCH: s_d.torch = rx;
                REG_ID:    soft_rst  = rx[ID_SWRST_BIT]; // R24
                default:   ;
            endcase
        end

        // data line driver, changed only on falling clock
        if (scl_rise && s_q.st == ST_READ && s_q.tx_cnt == 4'(BYTE_BITS)) begin
            s_d.mack = ~s_q.sda_s2; // controller ack of read data
        end
        if (scl_fall && s_q.busy) begin
            if (s_q.ack_on) begin
                s_d.ack_on = 1'b0;
                s_d.sda_oe = 1'b0;
                load       = (s_q.st == ST_READ);
            end else if (s_q.ack_pend) begin
                s_d.ack_pend = 1'b0;
                s_d.ack_on   = 1'b1;
                s_d.sda_oe   = 1'b1; // R6
            end else if (s_q.st == ST_READ) begin
                if (s_q.tx_cnt < 4'(BYTE_BITS - 1)) begin
                    s_d.tx     = {s_q.tx[6:0], 1'b0}; // R5
                    s_d.sda_oe = ~s_q.tx[6];
                    s_d.tx_cnt = s_q.tx_cnt + 4'h1;
                end else if (s_q.tx_cnt == 4'(BYTE_BITS - 1)) begin
                    s_d.sda_oe = 1'b0; // R7
                    s_d.tx_cnt = 4'(BYTE_BITS);
                end else if (s_q.mack) begin
                    load = 1'b1;
                end else begin
                    s_d.st = ST_IDLE; // controller declined more data
                end
            end
        end
        if (load) begin
            s_d.tx     = reg_read(s_q);
            s_d.sda_oe = ~s_d.tx[7];
            s_d.tx_cnt = 4'h0;
            rd_clr     = (s_q.ptr == REG_FLAGS); // R23
        end

        // start and stop override everything on the bus side
        if (start_det) begin
            s_d.st       = ST_ADDR; // R4
            s_d.busy     = 1'b1;    // R3
            s_d.restart  = 1'b1;
            s_d.ack_pend = 1'b0;
            s_d.ack_on   = 1'b0;
            s_d.sda_oe   = 1'b0;
        end else if (stop_det) begin
            s_d.st       = ST_IDLE;
            s_d.busy     = 1'b0; // R3
            s_d.restart  = 1'b1;
            s_d.ack_pend = 1'b0;
            s_d.ack_on   = 1'b0;
            s_d.sda_oe   = 1'b0;
        end

        // software reset returns the control registers to power-on values
        if (soft_rst) begin
            s_d.op    = OP_RST; // R24
            s_d.setup = SETUP_RST;
            s_d.flash = FLASH_RST;
            s_d.torch = TORCH_RST;
            s_d.flags = FLAGS_RST;
            s_d.lock  = 1'b0;
        end

        // sticky flags: a new event beats the read-clear R23
        if (rd_clr) begin
            s_d.flags = 8'h00;
            s_d.lock  = 1'b0;
        end
        s_d.flags = s_d.flags | s_q.flt_s2;
        if ((s_q.flt_s2 & STANDBY_FAULTS) != 8'h00) begin
            s_d.lock                   = 1'b1; // R23
            s_d.op[OP_MODE_LSB +: 2]   = MODE_STANDBY;
        end

        // led source: target pick and stepped approach
        mode   = s_q.lock ? MODE_STANDBY : s_q.op[OP_MODE_LSB +: 2]; // R15
        target = s_q.flash[6:0]; // R21
        if (mode == MODE_TORCH) begin
            target = s_q.torch[6:0];
        end else if (mode == MODE_FLASH && s_q.flash[FLASH_TSB_BIT]
                     && s_q.flt_s2[FLAG_TSB_BIT]) begin
            target = s_q.torch[6:0]; // R22
        end
        s_d.led_on = (mode != MODE_STANDBY);
        if (!s_d.led_on) begin
            s_d.level    = 7'h00;
            s_d.step_cnt = 10'h000;
        end else if (mode == MODE_TORCH && s_q.setup[SETUP_RAMP_BIT]) begin
            // ramp spreads the full range over the torch ramp time R20
            if (s_q.step_cnt == 10'(RAMP_STEP_CYC - 1)) begin
                s_d.step_cnt = 10'h000;
                s_d.level    = step_toward(s_q.level, target); // R25
            end else begin
                s_d.step_cnt = s_q.step_cnt + 10'h001;
            end
        end else begin
            s_d.level = step_toward(s_q.level, target); // R25
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s_q <= S_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs, all straight from the state register
    // ----------------------------------------------------------------
    assign sda_out_out             = s_q.sda_lvl;
    assign sda_oe_out              = s_q.sda_oe;
    assign boost_pass_only_out     = s_q.op[OP_PASS_BIT];           // R10
    assign freq_4mhz_out           = s_q.op[OP_FREQ_BIT];           // R11
    assign ilim_high_out           = s_q.op[OP_ILIM_BIT];           // R12
    assign input_droop_monitor_out = s_q.op[OP_DROOP_BIT];          // R13
    assign strobe_edge_out         = s_q.op[OP_EDGE_BIT];           // R14
    assign mode_select_high_out    = s_q.op[OP_MODE_LSB + 1];       // R15
    assign mode_select_low_out     = s_q.op[OP_MODE_LSB];           // R15
    assign droop_threshold_out     = s_q.setup[SETUP_THR_LSB +: 3]; // R18
    assign timeout_code_out        = s_q.setup[SETUP_TO_LSB +: 4];  // R19
    assign torch_ramp_out          = s_q.setup[SETUP_RAMP_BIT];     // R20
    assign thermal_scaleback_out   = s_q.flash[FLASH_TSB_BIT];      // R22
    assign led_level_out           = s_q.level;
    assign led_on_out              = s_q.led_on;
    assign bus_busy_out            = s_q.busy;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);

    property p_start_busy;
        start_det |=> s_q.busy && s_q.st == ST_ADDR && s_q.restart;
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("start not taken"); // R3

    property p_stop_idle;
        stop_det |=> !s_q.busy && !s_q.sda_oe;
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("stop left bus busy"); // R3

    property p_repeat;
        start_det && s_q.busy |=> s_q.st == ST_ADDR && !s_q.ack_pend && !s_q.sda_oe;
    endproperty
    a_repeat: assert property (p_repeat) else $error("repeated start ignored"); // R4

    property p_ack_drive;
        scl_fall && s_q.busy && s_q.ack_pend && !s_q.ack_on && !start_det && !stop_det
            |=> s_q.sda_oe && !sda_out_out;
    endproperty
    a_ack_drive: assert property (p_ack_drive) else $error("ack not driven"); // R6

    property p_no_read_ack;
        scl_fall && s_q.st == ST_READ && s_q.tx_cnt == 4'h7 && !s_q.ack_on
            && !s_q.ack_pend && s_q.busy && !start_det && !stop_det |=> !s_q.sda_oe;
    endproperty
    a_no_read_ack: assert property (p_no_read_ack) else $error("ack after read"); // R7

    property p_addr_miss;
        byte_evt && s_q.st == ST_ADDR && rx[7:1] != TARGET_ADDR && !start_det && !stop_det
            |=> s_q.st == ST_IDLE && !s_q.ack_pend;
    endproperty
    a_addr_miss: assert property (p_addr_miss) else $error("foreign address answered"); // R8

    property p_soft_rst;
        wr_evt && s_q.ptr == REG_ID && rx[ID_SWRST_BIT] && s_q.flt_s2 == 8'h00
            |=> s_q.op == OP_RST && s_q.setup == SETUP_RST;
    endproperty
    a_soft_rst: assert property (p_soft_rst) else $error("soft reset missed"); // R24

    property p_flag_sticky;
        s_q.flt_s2 != 8'h00 |=> (s_q.flags & $past(s_q.flt_s2)) == $past(s_q.flt_s2);
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("fault flag lost"); // R23

    property p_fault_standby;
        (s_q.flt_s2 & STANDBY_FAULTS) != 8'h00 |=> s_q.lock ##1 !led_on_out;
    endproperty
    a_fault_standby: assert property (p_fault_standby) else $error("fault kept led on"); // R23

    property p_ramp;
        led_on_out && $past(led_on_out) |-> (led_level_out == $past(led_level_out))
            || (led_level_out == $past(led_level_out) + 7'h01)
            || (led_level_out == $past(led_level_out) - 7'h01);
    endproperty
    a_ramp: assert property (p_ramp) else $error("led level jumped"); // R25

    c_write: cover property (wr_evt && s_q.ptr == REG_OP);
    c_flag_read: cover property (load && s_q.ptr == REG_FLAGS);
    c_restart: cover property (start_det && s_q.busy);
    c_ramp_top: cover property (led_on_out && led_level_out == 7'h7F);
endmodule

// [bus_ctrl_model.sv]
`timescale 1ns/1ps
// ----------------------------------------
// serial bus controller model
// ----------------------------------------
module bus_ctrl_model (
    input  wire logic lclk_in,
    input  wire logic sda_w_in,
    output logic      scl_out,
    output logic      sda_rel_out
);
    // clock idles high, data released to the pull-up
    initial begin
        scl_out = 1'b1;
        sda_rel_out = 1'b1;
    end
    // half bit: 72 ns, above what the oversampled side needs
    task automatic half();
        repeat (12) @(posedge lclk_in);
    endtask
    // start and repeated start are the same sequence
    task automatic start();
        sda_rel_out <= 1'b1;
        half();
        scl_out <= 1'b1;
        half();
        sda_rel_out <= 1'b0;
        half();
        scl_out <= 1'b0;
        repeat (2) @(posedge lclk_in);
    endtask
    task automatic stop();
        sda_rel_out <= 1'b0;
        half();
        scl_out <= 1'b1;
        half();
        sda_rel_out <= 1'b1;
        half();
    endtask
    // data moves only with clock low, sampled late in the high phase
    task automatic bit_x(input logic b, output logic s);
        sda_rel_out <= b;
        half();
        scl_out <= 1'b1;
        half();
        s = sda_w_in;
        scl_out <= 1'b0;
        repeat (2) @(posedge lclk_in);
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], s);
        end
        bit_x(1'b1, s);
        ack = ~s;
    endtask
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, d[i]);
        end
        bit_x(last, s);
    endtask
endmodule

// [flash_serial_ctrl_tb.sv]
`timescale 1ns/1ps
// ----------------------------------------
// flash controller bench
// ----------------------------------------
module flash_serial_ctrl_tb;
    import flash_ctrl_pkg::*;
    logic       mclk, lclk, rst_b, sda_oe, sda_rel, scl, busy, led_on, pass, frq;
    logic       ilim, drp, edg, mh, ml, ramp, thermal_scaleback, sdo;
    logic [6:0] lvl;
    logic [7:0] faults, got;
    logic [7:0] exp_q[$];
    logic [2:0] thr;
    logic [3:0] to;
    int         mismatches, samples_checked;
    event       rd_ev;
    wire        sda_w = sda_rel & (~sda_oe | sdo); // pull-up wins when nobody pulls
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        lclk = 1'b0;
        #1.7;
        forever #3 lclk = ~lclk;
    end
    flash_serial_ctrl dut_u (.mclk_in(mclk), .rst_b_in(rst_b), .scl_in(scl), .sda_in(sda_w),
        .sda_out_out(sdo), .sda_oe_out(sda_oe), .fault_events_in(faults),
        .boost_pass_only_out(pass), .freq_4mhz_out(frq), .ilim_high_out(ilim),
        .input_droop_monitor_out(drp), .strobe_edge_out(edg), .mode_select_high_out(mh),
        .mode_select_low_out(ml), .droop_threshold_out(thr), .timeout_code_out(to),
        .torch_ramp_out(ramp), .thermal_scaleback_out(thermal_scaleback), .led_level_out(lvl),
        .led_on_out(led_on), .bus_busy_out(busy));
    bus_ctrl_model m_u (.lclk_in(lclk), .sda_w_in(sda_w), .scl_out(scl),
        .sda_rel_out(sda_rel));
    task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_op(input logic [7:0] e);
        check("op", {e[7:3], e[1:0], 1'b0}, {pass, frq, ilim, drp, edg, mh, ml, 1'b0});
    endtask
    task automatic wr(input logic [7:0] off, input logic [7:0] d);
        logic a0, a1, a2;
        m_u.start();
        m_u.wbyte({TARGET_ADDR, 1'b0}, a0);
        m_u.wbyte(off, a1);
        m_u.wbyte(d, a2);
        m_u.stop();
        check("ack", 8'h07, {5'h00, a0, a1, a2});
        repeat (10) @(negedge mclk);
        check("busy", 8'h00, {7'h00, busy});
    endtask
    // pointer by a write, then repeated start and one byte read
    task automatic rd(input logic [7:0] off, input logic [7:0] e);
        logic a;
        exp_q.push_back(e);
        m_u.start();
        m_u.wbyte({TARGET_ADDR, 1'b0}, a);
        m_u.wbyte(off, a);
        m_u.start();
        m_u.wbyte({TARGET_ADDR, 1'b1}, a);
        m_u.rbyte(1'b1, got);
        m_u.stop();
        -> rd_ev;
    endtask
    // watcher: oldest note against each read result
    initial begin
        forever begin
            @(rd_ev);
            check("read", exp_q.pop_front(), got);
        end
    end
    initial begin
        logic [7:0] r, v;
        logic       a;
        faults = 8'h00;
        rst_b = 1'b0;
        mismatches = 0;
        samples_checked = 0;
        r = $urandom(32'h452f);
        repeat (16) @(negedge mclk);
        rst_b = 1'b1;
        repeat (4) @(negedge mclk);
        chk_op(OP_RST);
        check("setup", SETUP_RST, {thr, to, ramp});
        // trigger pin lives outside this block, so no pulse width to hold
        for (int m = 0; m < 4; m++) begin
            r = $urandom();
            v = {r[7:4], (m == 1) ? 1'b0 : r[3], 1'b0, m[1:0]};
            wr(REG_OP, v);
            chk_op(v);
            rd(REG_OP, v);
        end
        r = $urandom();
        wr(REG_SETUP, r);
        check("setup", r, {thr, to, ramp});
        wr(REG_FLASH, r);
        check("tsb", {7'h00, r[7]}, {7'h00, thermal_scaleback});
        rd(REG_FLASH, r);
        // still in flash mode from the last loop pass, so level sits on target
        check("level", {1'b0, r[6:0]}, {1'b0, lvl});
        $display("test fields done");
        // fault turns the led off and forces the mode bits to standby, so it stays off after the flags are read
        faults = 8'h01;
        repeat (10) @(negedge mclk);
        check("lock", 8'h00, {5'h00, led_on, mh, ml});
        check("level", 8'h00, {1'b0, lvl});
        faults = 8'h00;
        rd(REG_FLAGS, 8'h01);
        rd(REG_FLAGS, 8'h00);
        $display("test fault done");
        m_u.start();
        m_u.wbyte({7'h65, 1'b0}, a);
        m_u.stop();
        check("nack", 8'h00, {7'h00, a});
        wr(8'h07, 8'hFF);
        rd(8'h07, 8'h00);
        rd(REG_ID, {2'b00, DEVICE_ID, SILICON_REV});
        wr(REG_ID, 8'h80);
        chk_op(OP_RST);
        $display("test misc done");
        repeat (20) @(negedge mclk);
        stop_test();
    end
    // bounded watchdog, well above the ten thousand or so cycles a clean run takes
    initial begin
        repeat (40000) @(posedge mclk);
        mismatches++;
        stop_test();
    end
    task automatic stop_test();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
endmodule
